// ==== verilog/gfp_pkg.sv ====
// Package for the general purpose flag port: widths, reset values, structs
`default_nettype none
package gfp_pkg;
  // ==========================================
  // Widths and reset values
  localparam int unsigned GFP_NUM_PINS = 48;
  localparam int unsigned GFP_NUM_SEL = 7;
  localparam int unsigned GFP_SS_PIN = 0;        // Pin reused as slave select input
  localparam int unsigned GFP_SEL_BASE = 1;      // First pin reused as device select
  localparam logic [47:0] GFP_ZERO = 48'h0;
  localparam logic GFP_DIR_IN = 1'b0;            // Direction bit: 0 input, 1 output
  localparam logic GFP_SENS_LEVEL = 1'b0;        // Sensitivity bit: 0 level, 1 edge
  localparam logic GFP_EDGE_RISE = 1'b0;         // Edge bit: 0 rising only, 1 both

  // ==========================================
  // Software write strobes with their data word
  typedef struct packed {
    logic dir_we;
    logic set_we;
    logic clr_we;
    logic mask_set_we;
    logic mask_clr_we;
    logic sens_we;
    logic edge_we;
    logic evt_clr_we;
    logic [47:0] wdata;
  } gfp_wr_t;

  // Serial port takeover of the select pins
  typedef struct packed {
    logic ss_en;
    logic [6:0] sel_en;
    logic [6:0] sel_val;
  } gfp_spi_t;
endpackage : gfp_pkg
`default_nettype wire

// ==== verilog/gfp_sync.sv ====
// Two-stage input synchroniser with edge detection for the flag pins
`default_nettype none
module gfp_sync
  import gfp_pkg::*;
#(
  parameter int unsigned WIDTH = 48
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // ==========================================
  // Sync stages then history register
  // two flop sync
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule : gfp_sync
`default_nettype wire

// ==== verilog/gfp_port.sv ====
// General purpose flag port: 48 bidirectional pins with set/clear and interrupts
// Contract
// - Forty-eight individually controlled bidirectional flag pins.
// - Direction register, one bit per pin.
// - Write ones to set flag values.
// - Write ones to clear flag values.
// - Status read returns current pin sense.
// - Write ones to enable pin interrupts.
// - Write ones to disable pin interrupts.
// - Enabled input activity raises hardware interrupt.
// - Enabled output software change raises software interrupt.
// - Per pin level or edge sensitivity.
// - Per pin rising-only or both edges.
// - Serial port takes over select pins.
`default_nettype none
module gfp_port
  import gfp_pkg::*;
#(
  parameter int unsigned NUM_PINS = GFP_NUM_PINS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire gfp_wr_t wr,
  input wire gfp_spi_t spi,
  input wire logic [NUM_PINS-1:0] flag_pin_bank_in,
  output logic [NUM_PINS-1:0] flag_pin_bank_out,
  output logic [NUM_PINS-1:0] flag_pin_bank_oe_n,
  output logic [NUM_PINS-1:0] dir_rd,
  output logic [NUM_PINS-1:0] flag_val_rd,
  output logic [NUM_PINS-1:0] flag_status,
  output logic [NUM_PINS-1:0] mask_rd,
  output logic [NUM_PINS-1:0] sens_rd,
  output logic [NUM_PINS-1:0] edge_rd,
  output logic [NUM_PINS-1:0] evt_pending,
  output logic serial_slave_select_in,
  output logic hw_irq,
  output logic sw_irq
);
  // ==========================================
  // Elaboration check
  if (NUM_PINS != GFP_NUM_PINS) begin : g_bad_width
    $error("gfp_port supports exactly 48 flag pins");
  end

  logic [NUM_PINS-1:0] dir_q, dir_d;
  logic [NUM_PINS-1:0] val_q, val_d;
  logic [NUM_PINS-1:0] mask_q, mask_d;
  logic [NUM_PINS-1:0] sens_q;
  logic [NUM_PINS-1:0] edge_q;
  logic [NUM_PINS-1:0] evt_q, evt_d;
  logic [NUM_PINS-1:0] swchg_q, swchg_d;
  logic [NUM_PINS-1:0] pin_lvl, pin_rise, pin_fall;
  logic [NUM_PINS-1:0] sel_own, sel_val, eff_dir, eff_out;
  logic [NUM_PINS-1:0] ss_force;
  logic [NUM_PINS-1:0] sense_w, edge_hit, sw_hit, lvl_req;
  logic hw_irq_q, sw_irq_q, ss_q;

  // ==========================================
  // Input synchroniser
  gfp_sync #(.WIDTH(NUM_PINS)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(flag_pin_bank_in),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ==========================================
  // Serial port takeover map
  // select pin reuse
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sel
      if (gi >= GFP_SEL_BASE && gi < GFP_SEL_BASE + GFP_NUM_SEL) begin : g_own
        assign sel_own[gi] = spi.sel_en[gi-GFP_SEL_BASE];
        assign sel_val[gi] = spi.sel_val[gi-GFP_SEL_BASE];
        assign ss_force[gi] = 1'b0;
      end else if (gi == GFP_SS_PIN) begin : g_ss
        assign sel_own[gi] = spi.ss_en;
        assign sel_val[gi] = 1'b0;
        assign ss_force[gi] = spi.ss_en;
      end else begin : g_none
        assign sel_own[gi] = 1'b0;
        assign sel_val[gi] = 1'b0;
        assign ss_force[gi] = 1'b0;
      end
    end
  endgenerate

  // Slave select pin is forced to input while owned; select outputs forced out
  assign eff_dir = (dir_q & ~sel_own) | (sel_own & ~ss_force);
  assign eff_out = (val_q & ~sel_own) | (sel_val & sel_own);

  // ==========================================
  // Next-value decode for the direction register and the set/clear registers
  // direction write
  assign dir_d = wr.dir_we ? wr.wdata : dir_q;
  assign val_d = (val_q | (wr.set_we ? wr.wdata : GFP_ZERO)) & ~(wr.clr_we ? wr.wdata : GFP_ZERO);
  assign mask_d = (mask_q | (wr.mask_set_we ? wr.wdata : GFP_ZERO))
                  & ~(wr.mask_clr_we ? wr.wdata : GFP_ZERO);

  // ==========================================
  // Event sense per pin
  // level or edge
  assign edge_hit = sens_q & ~eff_dir & (pin_rise | (edge_q & pin_fall));
  assign lvl_req = ~sens_q & ~eff_dir & pin_lvl & mask_q;
  assign sw_hit = eff_dir & (val_d ^ val_q) & ~sel_own;
  assign evt_d = (evt_q & ~(wr.evt_clr_we ? wr.wdata : GFP_ZERO)) | edge_hit;
  assign swchg_d = (swchg_q & ~(wr.evt_clr_we ? wr.wdata : GFP_ZERO)) | sw_hit;
  // Per pin: driven value on outputs, synchronised level on inputs
  assign sense_w = (eff_dir & eff_out) | (~eff_dir & pin_lvl);

  // ==========================================
  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= {NUM_PINS{GFP_DIR_IN}};
      val_q <= GFP_ZERO;
      mask_q <= GFP_ZERO;
      sens_q <= {NUM_PINS{GFP_SENS_LEVEL}};
      edge_q <= {NUM_PINS{GFP_EDGE_RISE}};
    end else begin
      dir_q <= dir_d;
      val_q <= val_d;
      mask_q <= mask_d;
      if (wr.sens_we) begin
        sens_q <= wr.wdata;
      end
      if (wr.edge_we) begin
        edge_q <= wr.wdata;
      end
    end
  end

  // Event latches and interrupt outputs
  // hardware interrupt
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= GFP_ZERO;
      swchg_q <= GFP_ZERO;
      hw_irq_q <= 1'b0;
      sw_irq_q <= 1'b0;
      ss_q <= 1'b1;
    end else begin
      evt_q <= evt_d;
      swchg_q <= swchg_d;
      hw_irq_q <= |((evt_d & mask_d) | lvl_req);
      sw_irq_q <= |(swchg_d & mask_d);
      ss_q <= spi.ss_en ? pin_lvl[GFP_SS_PIN] : 1'b1;
    end
  end

  // ==========================================
  // Outputs
  // pin drive
  assign flag_pin_bank_out = eff_out;
  assign flag_pin_bank_oe_n = ~eff_dir;
  assign dir_rd = dir_q;
  assign flag_val_rd = val_q;
  assign flag_status = sense_w;
  assign mask_rd = mask_q;
  assign sens_rd = sens_q;
  assign edge_rd = edge_q;
  assign evt_pending = evt_q | swchg_q;
  assign serial_slave_select_in = ss_q;
  assign hw_irq = hw_irq_q;
  assign sw_irq = sw_irq_q;

  // ==========================================
  // Checks
  // set takes effect
  set_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr.set_we && !wr.clr_we |=> ((val_q & $past(wr.wdata)) == $past(wr.wdata)))
    else $error("set bits not set");
  clr_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr.clr_we |=> ((val_q & $past(wr.wdata)) == GFP_ZERO))
    else $error("clear bits not cleared");
  hold_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr.set_we && !wr.clr_we |=> val_q == $past(val_q))
    else $error("flags changed without write");
  mask_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr.mask_set_we && !wr.mask_clr_we |=> ((mask_q & $past(wr.wdata)) == $past(wr.wdata)))
    else $error("mask set failed");
  mask_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr.mask_clr_we |=> ((mask_q & $past(wr.wdata)) == GFP_ZERO))
    else $error("mask clear failed");
  evt_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |evt_q && !wr.evt_clr_we |=> ((evt_q & $past(evt_q)) == $past(evt_q)))
    else $error("edge event lost");
  hw_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(evt_q & mask_q) |-> hw_irq)
    else $error("hardware interrupt missing");
  sync_lag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> ((flag_status ^ $past(flag_pin_bank_in, 2)) & ~eff_dir) == GFP_ZERO)
    else $error("input sync latency wrong");
endmodule : gfp_port
`default_nettype wire

// ==== sim/gfp_pin_board.sv ====
// Board side of the flag pins: resolves each pin level from both drivers
`default_nettype none
module gfp_pin_board (
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe_n,
  input wire logic [47:0] board_val,
  output logic [47:0] pin_level
);
  // ==========================================
  // Pin resolution
  // Device wins where its enable is low, the board drives every other pin
  assign pin_level = (pin_out & ~pin_oe_n) | (board_val & pin_oe_n);
endmodule : gfp_pin_board
`default_nettype wire

// ==== sim/tb_gfp_port.sv ====
// Self-checking testbench for the general purpose flag port
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_gfp_port
  import gfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals, clock and instances
  logic sys_clk = 1'b0;
  logic rst_n;
  gfp_wr_t wr;
  gfp_spi_t spi;
  logic [47:0] ext, pin_in, out, oe_n, dir, val, stat, mask, sens, edg, evt;
  logic ss, hw, sw;
  int failures = 0;
  int total_checks = 0;
  localparam logic [7:0] DIR = 8'h80, SET = 8'h40, CLR = 8'h20, MS = 8'h10;
  localparam logic [7:0] MC = 8'h08, SENS = 8'h04, EDG = 8'h02, EC = 8'h01;
  // Free running 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  gfp_pin_board u_gfp_pin_board (.pin_out(out), .pin_oe_n(oe_n), .board_val(ext),
    .pin_level(pin_in));
  gfp_port u_gfp_port (.sys_clk(sys_clk), .rst_n(rst_n), .wr(wr), .spi(spi),
    .flag_pin_bank_in(pin_in), .flag_pin_bank_out(out), .flag_pin_bank_oe_n(oe_n),
    .dir_rd(dir), .flag_val_rd(val), .flag_status(stat), .mask_rd(mask), .sens_rd(sens),
    .edge_rd(edg), .evt_pending(evt), .serial_slave_select_in(ss), .hw_irq(hw), .sw_irq(sw));
  // ==========================================
  // Access tasks
  // One-cycle write strobe, launched and dropped on falling edges
  task automatic wr_op(input logic [7:0] stb, input logic [47:0] d);
    @(negedge sys_clk);
    wr = {stb, d};
    @(negedge sys_clk);
    wr = '0;
  endtask : wr_op
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_n
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Watchdog: the tests need about 0.75 us
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
  // ==========================================
  // Test sequence
  initial begin
    rst_n = 1'b0;
    wr = '0;
    spi = '0;
    ext = '0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK(oe_n, ~GFP_ZERO)
    `CHK(ss, 1'b1)
    `CHK({hw, sw}, 2'b00)
    $display("test reset done");
    wr_op(DIR, 48'h0000_0000_ff00);
    `CHK(dir, 48'h0000_0000_ff00)
    `CHK(oe_n, ~48'h0000_0000_ff00)
    wr_op(SET, 48'h0f00);
    wr_op(SET, 48'hf000);
    `CHK(val, 48'hff00)
    wr_op(CLR, 48'h0300);
    `CHK(val, 48'hfc00)
    wr_op(SET | CLR, 48'h0c00);
    `CHK(val, 48'hf000)
    `CHK(out[15:8], 8'hf0)
    `CHK(stat[15:8], 8'hf0)
    $display("test set clear done");
    wr_op(MS, 48'h0003_0000);
    wr_op(MS, 48'h4000_0000);
    wr_op(MC, 48'h0002_0000);
    `CHK(mask, 48'h4001_0000)
    wr_op(SENS, 48'h0003_0000);
    wr_op(EDG, 48'h0002_0000);
    `CHK({sens[17:16], edg[17:16]}, 4'b1110)
    ext[17:16] = 2'b11;
    wait_n(4);
    `CHK(stat[17:16], 2'b11)
    `CHK(evt[17:16], 2'b11)
    `CHK(hw, 1'b1)
    wr_op(EC, 48'h0003_0000);
    wait_n(1);
    `CHK(evt[17:16], 2'b00)
    `CHK(hw, 1'b0)
    ext[17:16] = 2'b00;
    wait_n(4);
    `CHK(evt[17:16], 2'b10)
    `CHK(hw, 1'b0)
    wr_op(EC, 48'h0002_0000);
    $display("test edge done");
    ext[30] = 1'b1;
    wait_n(1);
    `CHK(stat[30], 1'b0)
    wait_n(3);
    `CHK(hw, 1'b1)
    ext[30] = 1'b0;
    wait_n(4);
    `CHK(hw, 1'b0)
    $display("test level done");
    wr_op(EC, 48'h0200);
    wr_op(MS, 48'h0200);
    `CHK(sw, 1'b0)
    wr_op(SET, 48'h0200);
    wait_n(1);
    `CHK(evt[9], 1'b1)
    `CHK(sw, 1'b1)
    wr_op(EC, 48'h0200);
    wait_n(1);
    `CHK(sw, 1'b0)
    $display("test soft irq done");
    spi.ss_en = 1'b1;
    spi.sel_en = 7'h01;
    spi.sel_val = 7'h01;
    wait_n(4);
    `CHK(ss, 1'b0)
    `CHK({oe_n[1], out[1]}, 2'b01)
    ext[0] = 1'b1;
    wait_n(4);
    `CHK(ss, 1'b1)
    $display("test serial select done");
    report_and_stop();
  end
endmodule : tb_gfp_port
`default_nettype wire
